// ### hdl/eog_pkg.sv
// Contract
// R1: host keeps sense select bits 7 and 6 at zero.
// R2: bit 5 reverses channel 2 current, bit 4 channel 1; default off.
// R3: bits 3..0 enable sensing on ch2 neg, ch2 pos, ch1 neg, ch1 pos.
// R4: host ignores a status flag whose sense enable bit is clear.
// R5: status bits 3..0 are read-only electrode flags, 1 means off.
// R6: status bit 4 is read-only bias-drive flag, 1 means not connected.
// R7: status bit 6 selects modulator divider, 0 by 4, 1 by 16.
// R8: host writes 02h to misc control one at 09h.
// R9: misc two bit 7 enables offset calibration, default off.
// R10: misc two bit 1 selects internal bias reference, default external.
// R11: io bits 3..2 set pin direction, 0 output, 1 input default.
// R12: io data reads return real pin levels in either direction.
// R13: io data write drives the pin only while it is an output.
// R14: host writes io bits 7..4 as zero.
// R15: select code 0110 routes bias input to positive, 0111 to negative.
// R16: host does not measure on a channel carrying the bias input.
// R17: electrode flags come from comparators powered by a separate enable.
// R18: comparator outputs and pin levels are synchronised before reading.
package eog_pkg;
    localparam logic [7:0] ADDR_SENSE = 8'h07;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MISC_CONTROL_ONE = 8'h09;
    localparam logic [7:0] ADDR_MISC_CONTROL_TWO = 8'h0a;
    localparam logic [7:0] ADDR_GPIO = 8'h0b;
    localparam logic [7:0] SENSE_WMASK = 8'h3f;
    localparam logic [7:0] MISC_CONTROL_ONE_RESET = 8'h02;
    localparam logic [7:0] MISC_CONTROL_TWO_WMASK = 8'h82;
    localparam int BIT_CLK_DIV = 6;
    localparam int BIT_BIAS_FLAG = 4;
    localparam int BIT_CALIB = 7;
    localparam int BIT_REF_INT = 1;
    localparam int DIR_LSB = 2;
    localparam logic [1:0] DIR_RESET = 2'h3;
    localparam logic [3:0] SEL_BIAS_POS = 4'h6;
    localparam logic [3:0] SEL_BIAS_NEG = 4'h7;
    localparam int SYNC_LEN = 3;
endpackage

// ### hdl/eog_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eog_sync_if;
    logic [6:0] raw;
    logic [6:0] clean;
    modport src (output raw, input clean);
    modport sync (input raw, output clean);
endinterface
`default_nettype wire

// ### hdl/eog_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage sampler; a change is taken when stages two and three agree
module eog_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    eog_sync_if.sync s
);
    logic [6:0] st1, st2, st3, hold;
    logic [6:0] next_st1, next_st2, next_st3, next_hold;
    genvar i;
    generate
        for (i = 0; i < 7; i++) begin : g_bit
            always_comb begin
                next_st1[i] = s.raw[i];
                next_st2[i] = st1[i];
                next_st3[i] = st2[i];
                next_hold[i] = (st2[i] == st3[i]) ? st3[i] : hold[i]; // [R18]
            end
        end
    endgenerate
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st1 <= 7'h00;
            st2 <= 7'h00;
            st3 <= 7'h00;
            hold <= 7'h00;
        end else if (clk_en) begin
            st1 <= next_st1;
            st2 <= next_st2;
            st3 <= next_st3;
            hold <= next_hold;
        end
    end
    assign s.clean = hold;
endmodule
`default_nettype wire

// ### hdl/eog_route.sv
`timescale 1ns/1ps
`default_nettype none
// decodes one channel's input select onto the bias-input switches
module eog_route (
    input wire logic [3:0] sel,
    output logic to_pos,
    output logic to_neg
);
    always_comb begin
        to_pos = (sel == eog_pkg::SEL_BIAS_POS); // [R15]
        to_neg = (sel == eog_pkg::SEL_BIAS_NEG); // [R15]
    end
endmodule
`default_nettype wire

// ### hdl/eog_regs.sv
`timescale 1ns/1ps
`default_nettype none
module eog_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [3:0] comp_off,
    input wire logic bias_comp_off,
    input wire logic comp_power,
    input wire logic [1:0] io_pin_in,
    output logic [1:0] io_pin_out,
    output logic [1:0] io_pin_oe,
    input wire logic [3:0] ch1_input_select,
    input wire logic [3:0] ch2_input_select,
    output logic [1:0] current_reverse,
    output logic [3:0] sense_enable,
    output logic clk_div16,
    output logic offset_calibration_enable,
    output logic bias_reference_internal,
    output logic [1:0] bias_to_pos,
    output logic [1:0] bias_to_neg
);
    // ======================================================
    // input sampling
    eog_sync_if sif();
    assign sif.raw = {io_pin_in, bias_comp_off, comp_off};
    eog_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .s(sif.sync)
    );
    logic [3:0] flags_s;
    logic bias_s;
    logic [1:0] pins_s;
    assign flags_s = sif.clean[3:0];
    assign bias_s = sif.clean[4];
    assign pins_s = sif.clean[6:5];

    // ======================================================
    // bias input routing
    logic [1:0] rt_pos, rt_neg;
    eog_route u_r1 (.sel(ch1_input_select), .to_pos(rt_pos[0]), .to_neg(rt_neg[0]));
    eog_route u_r2 (.sel(ch2_input_select), .to_pos(rt_pos[1]), .to_neg(rt_neg[1]));

    // ======================================================
    // registers
    logic [7:0] sense, misc_control_one, misc_control_two;
    logic div_sel;
    logic [1:0] dir, dout;
    logic [7:0] next_sense, next_misc_control_one, next_misc_control_two;
    logic next_div_sel;
    logic [1:0] next_dir, next_dout;
    logic [7:0] next_rdata;
    logic [3:0] flags_q, next_flags_q;
    logic bias_q, next_bias_q;

    always_comb begin
        next_sense = sense;
        next_misc_control_one = misc_control_one;
        next_misc_control_two = misc_control_two;
        next_div_sel = div_sel;
        next_dir = dir;
        next_dout = dout;
        // comparators powered down read as connected
        next_flags_q = comp_power ? flags_s : 4'h0; // [R17] [R5]
        next_bias_q = comp_power ? bias_s : 1'b0; // [R6]
        if (wr) begin
            case (addr)
                eog_pkg::ADDR_SENSE: next_sense = wdata & eog_pkg::SENSE_WMASK; // [R2] [R3]
                eog_pkg::ADDR_STATUS: next_div_sel = wdata[eog_pkg::BIT_CLK_DIV]; // [R7]
                eog_pkg::ADDR_MISC_CONTROL_ONE: next_misc_control_one = wdata;
                eog_pkg::ADDR_MISC_CONTROL_TWO: next_misc_control_two = wdata & eog_pkg::MISC_CONTROL_TWO_WMASK; // [R9] [R10]
                eog_pkg::ADDR_GPIO: begin
                    next_dir = wdata[eog_pkg::DIR_LSB +: 2]; // [R11]
                    // latch always, but only an output pin shows it
                    next_dout = wdata[1:0];
                end
                default: ;
            endcase
        end
        next_rdata = 8'h00;
        if (rd) begin
            case (addr)
                eog_pkg::ADDR_SENSE: next_rdata = sense;
                eog_pkg::ADDR_STATUS: begin
                    next_rdata[3:0] = flags_q; // [R5]
                    next_rdata[eog_pkg::BIT_BIAS_FLAG] = bias_q; // [R6]
                    next_rdata[eog_pkg::BIT_CLK_DIV] = div_sel; // [R7]
                end
                eog_pkg::ADDR_MISC_CONTROL_ONE: next_rdata = misc_control_one;
                eog_pkg::ADDR_MISC_CONTROL_TWO: next_rdata = misc_control_two;
                eog_pkg::ADDR_GPIO: next_rdata = {4'h0, dir, pins_s}; // [R12]
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sense <= 8'h00;
            misc_control_one <= eog_pkg::MISC_CONTROL_ONE_RESET;
            misc_control_two <= 8'h00;
            div_sel <= 1'b0;
            dir <= eog_pkg::DIR_RESET;
            dout <= 2'h0;
            rdata <= 8'h00;
            flags_q <= 4'h0;
            bias_q <= 1'b0;
        end else if (clk_en) begin
            sense <= next_sense;
            misc_control_one <= next_misc_control_one;
            misc_control_two <= next_misc_control_two;
            div_sel <= next_div_sel;
            dir <= next_dir;
            dout <= next_dout;
            rdata <= next_rdata;
            flags_q <= next_flags_q;
            bias_q <= next_bias_q;
        end
    end

    // ======================================================
    // registered outputs
    logic [1:0] next_pin_out, next_pin_oe, next_rev, next_bpos, next_bneg;
    logic [3:0] next_sen;
    logic next_div16, next_cal, next_ref;
    always_comb begin
        next_pin_oe = ~next_dir; // [R11]
        next_pin_out = next_dout & ~next_dir; // [R13]
        next_rev = next_sense[5:4]; // [R2]
        next_sen = next_sense[3:0]; // [R3]
        next_div16 = next_div_sel; // [R7]
        next_cal = next_misc_control_two[eog_pkg::BIT_CALIB]; // [R9]
        next_ref = next_misc_control_two[eog_pkg::BIT_REF_INT]; // [R10]
        next_bpos = rt_pos;
        next_bneg = rt_neg;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_pin_oe <= 2'h0;
            io_pin_out <= 2'h0;
            current_reverse <= 2'h0;
            sense_enable <= 4'h0;
            clk_div16 <= 1'b0;
            offset_calibration_enable <= 1'b0;
            bias_reference_internal <= 1'b0;
            bias_to_pos <= 2'h0;
            bias_to_neg <= 2'h0;
        end else if (clk_en) begin
            io_pin_oe <= next_pin_oe;
            io_pin_out <= next_pin_out;
            current_reverse <= next_rev;
            sense_enable <= next_sen;
            clk_div16 <= next_div16;
            offset_calibration_enable <= next_cal;
            bias_reference_internal <= next_ref;
            bias_to_pos <= next_bpos;
            bias_to_neg <= next_bneg;
        end
    end
endmodule
`default_nettype wire

// ### verif/eog_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module eog_regs_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic [1:0] io_pin_out,
    input wire logic [1:0] io_pin_oe,
    input wire logic [3:0] ch1_input_select,
    input wire logic [3:0] ch2_input_select,
    input wire logic [1:0] current_reverse,
    input wire logic [3:0] sense_enable,
    input wire logic clk_div16,
    input wire logic offset_calibration_enable,
    input wire logic bias_reference_internal,
    input wire logic [1:0] bias_to_pos,
    input wire logic [1:0] bias_to_neg
);
    logic ws;
    assign ws = wr && clk_en;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ==========
    // writes and input selects land on the outputs one cycle later
    sense_bits_a: assert property (ws && addr == eog_pkg::ADDR_SENSE |=>
        {current_reverse, sense_enable} == $past(wdata[5:0])) else $error("sense bits");
    clk_div_a: assert property (ws && addr == eog_pkg::ADDR_STATUS |=>
        clk_div16 == $past(wdata[6])) else $error("divider bit");
    calib_bit_a: assert property (ws && addr == eog_pkg::ADDR_MISC_CONTROL_TWO |=>
        offset_calibration_enable == $past(wdata[7])) else $error("calibration bit");
    ref_source_a: assert property (ws && addr == eog_pkg::ADDR_MISC_CONTROL_TWO |=>
        bias_reference_internal == $past(wdata[1])) else $error("reference bit");
    pin_dir_a: assert property (ws && addr == eog_pkg::ADDR_GPIO |=>
        io_pin_oe == ~$past(wdata[3:2])) else $error("pin direction");
    pin_drive_a: assert property (ws && addr == eog_pkg::ADDR_GPIO |=>
        io_pin_out == ($past(wdata[1:0]) & ~$past(wdata[3:2]))) else $error("pin drive");
    bias_pos_a: assert property (clk_en |=> bias_to_pos ==
        {$past(ch2_input_select) == 4'h6, $past(ch1_input_select) == 4'h6})
        else $error("bias to positive");
    bias_neg_a: assert property (clk_en |=> bias_to_neg ==
        {$past(ch2_input_select) == 4'h7, $past(ch1_input_select) == 4'h7})
        else $error("bias to negative");
    cover property (ws && addr == eog_pkg::ADDR_GPIO);
    cover property (bias_to_neg != 2'h0);
    cover property (io_pin_oe == 2'h3 ##1 io_pin_oe == 2'h0);
endmodule
bind eog_regs eog_regs_sva i_eog_regs_sva (.*);
`default_nettype wire

// ### verif/eog_host.sv
`timescale 1ns/1ps
`default_nettype none
module eog_host (
    input wire logic sys_clk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // callers pass only legal values: reserved bits zero, misc one fixed
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule
`default_nettype wire

// ### verif/eog_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module eog_regs_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] addr, wdata, rdata, got;
    logic wr, rd, clk_div16, offset_calibration_enable, bias_reference_internal;
    logic comp_power = 1'b0;
    logic bias_comp_off = 1'b0;
    logic [3:0] comp_off = 4'h0, ch1_input_select = 4'h0, ch2_input_select = 4'h0;
    logic [3:0] sense_enable;
    logic [1:0] io_pin_in, io_pin_out, io_pin_oe, current_reverse, bias_to_pos, bias_to_neg;
    logic [1:0] ext = 2'h2;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // {write, address, data, expected read}
    logic [27:0] rows [12] = '{28'h0070000, 28'h0080000, 28'h0090002, 28'h00a0000,
        28'h00b000e, 28'h1073535, 28'h1070a0a, 28'h1084040, 28'h1090202,
        28'h10a8282, 28'h10a8080, 28'h10c5500};
    // an undriven pin sits at the level the board gives it
    assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext);
    eog_regs i_eog_regs (.*);
    eog_host i_eog_host (.*);
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i][24]) begin
                i_eog_host.put(rows[i][23:16], rows[i][15:8]);
            end
            i_eog_host.get(rows[i][23:16], got);
            chk(got, rows[i][7:0]);
        end
        // data written while the pins are inputs must not reach them
        i_eog_host.put(8'h0b, 8'h0d);
        repeat (8) @(posedge sys_clk);
        i_eog_host.get(8'h0b, got);
        chk(got, 8'h0e);
        i_eog_host.put(8'h0b, 8'h01);
        repeat (8) @(posedge sys_clk);
        i_eog_host.get(8'h0b, got);
        chk(got, 8'h01);
        // all four sense enable bits on first, so every flag read back is meaningful
        i_eog_host.put(8'h07, 8'h0f);
        comp_power <= 1'b1;
        comp_off <= 4'h9;
        bias_comp_off <= 1'b1;
        repeat (8) @(posedge sys_clk);
        i_eog_host.get(8'h08, got);
        chk(got, 8'h59);
        // routed channels are only watched, never measured
        for (int s = 0; s < 16; s++) begin
            ch1_input_select <= 4'(s);
            ch2_input_select <= 4'(15 - s);
            @(posedge sys_clk);
        end
        ch1_input_select <= 4'h6;
        ch2_input_select <= 4'h7;
        repeat (2) @(posedge sys_clk);
        #1 chk({4'h0, bias_to_pos, bias_to_neg}, 8'h06);
        // a write while the clock enable is low must leave misc control two frozen
        @(posedge sys_clk);
        clk_en <= 1'b0;
        ch1_input_select <= 4'h0;
        ch2_input_select <= 4'h0;
        i_eog_host.put(8'h0a, 8'h02);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        i_eog_host.get(8'h0a, got);
        chk(got, 8'h80);
        // mid-run reset brings back the defaults; pins read back after the sampler settles
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        i_eog_host.get(8'h0a, got);
        chk(got, 8'h00);
        i_eog_host.get(8'h07, got);
        chk(got, 8'h00);
        i_eog_host.get(8'h0b, got);
        chk(got, 8'h0e);
        complete_run();
    end
endmodule
`default_nettype wire
